// file: rtl/aasu_core.v
// Accumulator arithmetic and store unit: sequencer, registers, memory port
`timescale 1ns/1ps
`include "aasu_regs.vh"
module aasu_core #(
    parameter W = `AASU_W
) (
    input  wire                  i_sys_clk,
    input  wire                  i_nrst,
    input  wire                  i_start,
    input  wire [`AASU_OP_W-1:0] i_op,
    input  wire [W-1:0]          i_addr,
    input  wire                  i_acc_we,
    input  wire [W-1:0]          i_acc_wdata,
    input  wire                  i_ext_we,
    input  wire [W-1:0]          i_ext_wdata,
    output wire                  o_mem_req,
    output reg                   o_mem_we,
    output reg  [W-1:0]          o_mem_addr,
    output reg  [W-1:0]          o_mem_wdata,
    input  wire                  i_mem_ack,
    input  wire [W-1:0]          i_mem_rdata,
    output reg  [W-1:0]          o_acc,
    output reg  [W-1:0]          o_ext,
    output reg                   o_carry,
    output reg                   o_ovf,
    output wire                  o_busy,
    output reg                   o_done
);
    // Latencies rounded up to whole clocks, never shorter than spec
    localparam MUL_CYC = (`AASU_MUL_HW_NS + `AASU_CLK_NS - 1) / `AASU_CLK_NS;
    localparam DIV_CYC = (`AASU_DIV_HW_NS + `AASU_CLK_NS - 1) / `AASU_CLK_NS;
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_RD1   = 4'h1;
    localparam [3:0] S_RD2   = 4'h2;
    localparam [3:0] S_WR1   = 4'h3;
    localparam [3:0] S_WR2   = 4'h4;
    localparam [3:0] S_MULW  = 4'h5;
    localparam [3:0] S_DIVW  = 4'h6;
    localparam [3:0] S_EXEC  = 4'h7;

    reg [3:0]            st_r;
    reg [`AASU_OP_W-1:0] op_r;
    reg [W-1:0]          addr_r;
    reg [W-1:0]          opnd_r;
    reg                  req_r;
    reg                  mul_go_r;
    reg                  div_go_r;
    wire [2*W-1:0]       prod;
    wire                 mul_done;
    wire [W-1:0]         quot;
    wire [W-1:0]         rem;
    wire                 div_fault;
    wire                 div_done;

    // Sign/zero flag encoding shared by several instructions
    function [1:0] sgn_flags;
        input [W-1:0] v;
        begin
            if (v == {W{1'b0}})
                sgn_flags = 2'b10;
            else if (v[W-1])
                sgn_flags = 2'b01;
            else
                sgn_flags = 2'b00;
        end
    endfunction

    // Sum with carry out and signed overflow: {carry, ovf, sum}
    function [W+1:0] add_cv;
        input [W-1:0] a;
        input [W-1:0] b;
        input         sub;
        reg   [W:0]   s;
        reg   [W-1:0] bb;
        begin
            // Subtract as inverse plus one; carry then means no borrow
            bb = sub ? ~b : b;
            s = {1'b0, a} + {1'b0, bb} + {{W{1'b0}}, sub};
            add_cv = {s[W], (a[W-1] == bb[W-1]) && (s[W-1] != a[W-1]), s[W-1:0]};
        end
    endfunction

    wire [W+1:0] sum_cv = add_cv(o_acc, opnd_r, op_r == `AASU_OP_SUB);
    wire [W-1:0] merged = (opnd_r & ~o_ext) | (o_acc & o_ext);

    assign o_mem_req = req_r;
    assign o_busy    = (st_r != S_IDLE);

    aasu_mul #(
        .W      (W),
        .CYCLES (MUL_CYC)
    ) u_mul (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_start   (mul_go_r),
        .i_a       (o_acc),
        .i_b       (opnd_r),
        .o_prod    (prod),
        .o_done    (mul_done)
    );

    aasu_div #(
        .W      (W),
        .CYCLES (DIV_CYC)
    ) u_div (
        .i_sys_clk  (i_sys_clk),
        .i_nrst     (i_nrst),
        .i_start    (div_go_r),
        .i_dividend ({o_ext, o_acc}),
        .i_divisor  (opnd_r),
        .o_quot     (quot),
        .o_rem      (rem),
        .o_fault    (div_fault),
        .o_done     (div_done)
    );

    // Single sequencer, one instruction in flight at a time
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_r <= S_IDLE;
            op_r <= `AASU_OP_NONE;
            addr_r <= {W{1'b0}};
            opnd_r <= {W{1'b0}};
            req_r <= 1'b0;
            mul_go_r <= 1'b0;
            div_go_r <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= {W{1'b0}};
            o_mem_wdata <= {W{1'b0}};
            o_acc <= {W{1'b0}};
            o_ext <= {W{1'b0}};
            o_carry <= 1'b0;
            o_ovf <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            mul_go_r <= 1'b0;
            div_go_r <= 1'b0;

            case (st_r)

                S_IDLE: begin
                    // Direct loads only while idle so no instruction races them
                    if (i_acc_we)
                        o_acc <= i_acc_wdata;
                    if (i_ext_we)
                        o_ext <= i_ext_wdata;
                    if (i_start) begin
                        op_r <= i_op;
                        addr_r <= i_addr;
                        o_mem_addr <= i_addr;
                        req_r <= 1'b1;
                        if (i_op == `AASU_OP_PSTORE) begin
                            o_mem_we <= 1'b1;
                            o_mem_wdata <= o_ext;
                            st_r <= S_WR1;
                        end else begin
                            o_mem_we <= 1'b0;
                            st_r <= S_RD1;
                        end
                    end
                end

                S_RD1: begin
                    if (i_mem_ack) begin
                        req_r <= 1'b0;
                        opnd_r <= i_mem_rdata;
                        if (op_r == `AASU_OP_PLOAD) begin
                            o_ext <= i_mem_rdata;
                            o_mem_addr <= addr_r + `AASU_PAIR_STEP;
                            req_r <= 1'b1;
                            st_r <= S_RD2;
                        end else begin
                            st_r <= S_EXEC;
                        end
                    end
                end

                S_RD2: begin
                    if (i_mem_ack) begin
                        req_r <= 1'b0;
                        o_acc <= i_mem_rdata;
                        // Flags follow the extension word loaded one access earlier
                        {o_carry, o_ovf} <= sgn_flags(o_ext);
                        o_done <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end

                // Operand settles one cycle before the arithmetic uses it
                S_EXEC: begin
                    st_r <= S_IDLE;
                    case (op_r)
                        `AASU_OP_MMSTORE: begin
                            // Accumulator and extension left as they are
                            o_mem_we <= 1'b1;
                            o_mem_wdata <= merged;
                            req_r <= 1'b1;
                            {o_carry, o_ovf} <= sgn_flags(merged);
                            st_r <= S_WR2;
                        end

                        `AASU_OP_ADD, `AASU_OP_SUB: begin
                            o_acc <= sum_cv[W-1:0];
                            o_carry <= sum_cv[W+1];
                            o_ovf <= sum_cv[W];
                            o_done <= 1'b1;
                        end

                        `AASU_OP_ADDMEM: begin
                            o_acc <= sum_cv[W-1:0];
                            o_carry <= sum_cv[W+1];
                            o_ovf <= sum_cv[W];
                            o_mem_we <= 1'b1;
                            o_mem_wdata <= sum_cv[W-1:0];
                            req_r <= 1'b1;
                            st_r <= S_WR2;
                        end

                        `AASU_OP_MUL: begin
                            mul_go_r <= 1'b1;
                            st_r <= S_MULW;
                        end

                        `AASU_OP_DIV: begin
                            div_go_r <= 1'b1;
                            st_r <= S_DIVW;
                        end
                        default: begin
                            o_done <= 1'b1;
                        end
                    endcase
                end

                // Request stays up; only address and data move to the second word
                S_WR1: begin
                    if (i_mem_ack) begin
                        o_mem_addr <= addr_r + `AASU_PAIR_STEP;
                        o_mem_wdata <= o_acc;
                        st_r <= S_WR2;
                    end
                end

                S_WR2: begin
                    if (i_mem_ack) begin
                        req_r <= 1'b0;
                        o_mem_we <= 1'b0;
                        o_done <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end

                // Product taken only on the done pulse, never mid-count
                S_MULW: begin
                    if (mul_done) begin
                        o_ext <= prod[2*W-1:W];
                        o_acc <= prod[W-1:0];
                        {o_carry, o_ovf} <= sgn_flags(prod[2*W-1:W]);
                        o_done <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end

                S_DIVW: begin
                    if (div_done) begin
                        if (div_fault) begin
                            // Fault shows as carry and overflow together
                            o_carry <= 1'b1;
                            o_ovf <= 1'b1;
                        end else begin
                            o_acc <= quot;
                            o_ext <= rem;
                            {o_carry, o_ovf} <= sgn_flags(quot);
                        end
                        o_done <= 1'b1;
                        st_r <= S_IDLE;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule // aasu_core

// file: rtl/aasu_div.v
// Signed 32/16 restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
`include "aasu_regs.vh"
module aasu_div #(
    parameter W      = `AASU_W,
    parameter CYCLES = 364
) (
    input  wire             i_sys_clk,
    input  wire             i_nrst,
    input  wire             i_start,
    input  wire [2*W-1:0]   i_dividend,
    input  wire [W-1:0]     i_divisor,
    output reg  [W-1:0]     o_quot,
    output reg  [W-1:0]     o_rem,
    output reg              o_fault,
    output reg              o_done
);
    reg [2*W-1:0] rem_r;
    reg [2*W-1:0] quo_r;
    reg [2*W-1:0] dvs_r;
    reg           nq_r;
    reg           nr_r;
    reg [15:0]    cnt_r;
    reg           busy_r;
    wire [2*W-1:0] mag_d = i_dividend[2*W-1] ? -i_dividend : i_dividend;
    wire [W-1:0]   mag_v = i_divisor[W-1] ? -i_divisor : i_divisor;
    wire [2*W-1:0] trial = {rem_r[2*W-2:0], quo_r[2*W-1]};
    wire           fits  = trial >= dvs_r;
    wire [W-1:0]   q_s   = nq_r ? -quo_r[W-1:0] : quo_r[W-1:0];
    wire [W-1:0]   r_s   = nr_r ? -rem_r[W-1:0] : rem_r[W-1:0];
    // Magnitude must fit signed range; -2^15 allowed when negative
    wire           q_ovf = (quo_r[2*W-1:W] != {W{1'b0}}) ||
                           (quo_r[W-1] && !(nq_r && quo_r[W-2:0] == {(W-1){1'b0}}));
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rem_r <= {2*W{1'b0}};
            quo_r <= {2*W{1'b0}};
            dvs_r <= {2*W{1'b0}};
            nq_r <= 1'b0;
            nr_r <= 1'b0;
            cnt_r <= 16'h0000;
            busy_r <= 1'b0;
            o_quot <= {W{1'b0}};
            o_rem <= {W{1'b0}};
            o_fault <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                busy_r <= 1'b1;
                cnt_r <= 16'h0000;
                rem_r <= {2*W{1'b0}};
                quo_r <= mag_d;
                dvs_r <= {{W{1'b0}}, mag_v};
                nq_r <= i_dividend[2*W-1] ^ i_divisor[W-1];
                nr_r <= i_dividend[2*W-1];
                o_fault <= (i_divisor == {W{1'b0}});
            end else if (busy_r) begin
                if (cnt_r < 16'h0020) begin
                    rem_r <= fits ? trial - dvs_r : trial;
                    quo_r <= {quo_r[2*W-2:0], fits};
                end
                if (cnt_r >= CYCLES[15:0] - 16'h0001) begin
                    busy_r <= 1'b0;
                    o_done <= 1'b1;
                    o_quot <= q_s;
                    // Zero remainder always reported positive
                    o_rem <= r_s;
                    o_fault <= o_fault | q_ovf;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
        end
    end
endmodule // aasu_div

// file: rtl/aasu_mul.v
// Signed 16x16 multiplier with fixed latency
`timescale 1ns/1ps
`include "aasu_regs.vh"
module aasu_mul #(
    parameter W      = `AASU_W,
    parameter CYCLES = 324
) (
    input  wire             i_sys_clk,
    input  wire             i_nrst,
    input  wire             i_start,
    input  wire [W-1:0]     i_a,
    input  wire [W-1:0]     i_b,
    output reg  [2*W-1:0]   o_prod,
    output reg              o_done
);
    reg [15:0] cnt_r;
    reg        busy_r;
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r  <= 16'h0000;
            busy_r <= 1'b0;
            o_prod <= {2*W{1'b0}};
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                busy_r <= 1'b1;
                cnt_r  <= 16'h0000;
                o_prod <= $signed(i_a) * $signed(i_b);
            end else if (busy_r) begin
                // Hold done back to model instruction timing; o_prod is already set at start
                if (cnt_r >= CYCLES[15:0] - 16'h0001) begin
                    busy_r <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
        end
    end
endmodule // aasu_mul

// file: rtl/aasu_regs.vh
// Constants for the accumulator arithmetic and store unit
`ifndef AASU_REGS_VH
`define AASU_REGS_VH
`define AASU_W            16
`define AASU_OP_W         4
`define AASU_OP_NONE      4'h0
`define AASU_OP_MMSTORE   4'h1
`define AASU_OP_PLOAD     4'h2
`define AASU_OP_PSTORE    4'h3
`define AASU_OP_ADD       4'h4
`define AASU_OP_ADDMEM    4'h5
`define AASU_OP_SUB       4'h6
`define AASU_OP_MUL       4'h7
`define AASU_OP_DIV       4'h8
`define AASU_PAIR_STEP    16'h0002
`define AASU_CLK_NS       25
`define AASU_MUL_HW_NS    8100
`define AASU_MUL_BIT_NS   900
`define AASU_DIV_HW_NS    9100
`define AASU_DIV_BIT_NS   300
`endif

// file: tb/aasu_core_sva.sv
// Property checker for the accumulator arithmetic and store unit
`timescale 1ns/1ps
`include "aasu_regs.vh"
module aasu_core_sva #(
    parameter W = 16
) (
    input wire                  i_sys_clk,
    input wire                  i_nrst,
    input wire                  i_start,
    input wire [`AASU_OP_W-1:0] i_op,
    input wire [W-1:0]          i_addr,
    input wire                  o_mem_req,
    input wire                  o_mem_we,
    input wire [W-1:0]          o_mem_addr,
    input wire [W-1:0]          o_mem_wdata,
    input wire                  i_mem_ack,
    input wire [W-1:0]          i_mem_rdata,
    input wire [W-1:0]          o_acc,
    input wire [W-1:0]          o_ext,
    input wire                  o_carry,
    input wire                  o_ovf,
    input wire                  o_busy,
    input wire                  o_done
);
    reg  [3:0]            op_r;
    reg  [W-1:0]          acc0_r;
    reg  [W-1:0]          ext0_r;
    reg  [W-1:0]          rd_r;
    wire                  take = i_start && !o_busy;
    wire                  rd_ack = o_mem_req && !o_mem_we && i_mem_ack;
    wire [W:0]            sum_w = {1'b0, acc0_r} + {1'b0, rd_r};
    wire                  sum_ovf = (acc0_r[W-1] == rd_r[W-1]) && (sum_w[W-1] != acc0_r[W-1]);
    wire signed [2*W-1:0] prod_w = $signed(acc0_r) * $signed(rd_r);
    // Operands captured at take and read so results can be recomputed at done
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            op_r <= 4'h0;
            acc0_r <= {W{1'b0}};
            ext0_r <= {W{1'b0}};
            rd_r <= {W{1'b0}};
        end else begin
            if (take) begin
                op_r <= i_op;
                acc0_r <= o_acc;
                ext0_r <= o_ext;
            end
            if (rd_ack) begin
                rd_r <= i_mem_rdata;
            end
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    pstore_first_a: assert property (take && i_op == `AASU_OP_PSTORE |=> o_mem_req && o_mem_we
        && o_mem_addr == $past(i_addr) && o_mem_wdata == $past(o_ext)) else $error("pair store first write wrong");
    pload_first_a: assert property (take && i_op == `AASU_OP_PLOAD |=> o_mem_req && !o_mem_we
        && o_mem_addr == $past(i_addr)) else $error("pair load first read wrong");
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
        && $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("memory request changed before ack");
    merge_data_a: assert property (op_r == `AASU_OP_MMSTORE && o_mem_req && o_mem_we
        |-> o_mem_wdata == ((rd_r & ~o_ext) | (o_acc & o_ext))) else $error("merge store data wrong");
    regs_keep_a: assert property ((op_r == `AASU_OP_MMSTORE || op_r == `AASU_OP_PSTORE) && o_busy
        |=> $stable(o_acc) && $stable(o_ext)) else $error("registers changed during store");
    add_result_a: assert property (op_r == `AASU_OP_ADD && o_done
        |-> {o_carry, o_acc} == sum_w && o_ovf == sum_ovf) else $error("add result wrong");
    addmem_write_a: assert property (op_r == `AASU_OP_ADDMEM && o_mem_req && o_mem_we
        |-> o_mem_wdata == sum_w[W-1:0]) else $error("add to memory write wrong");
    sub_result_a: assert property (op_r == `AASU_OP_SUB && o_done |-> o_acc == acc0_r - rd_r)
        else $error("subtract result wrong");
    mul_product_a: assert property (op_r == `AASU_OP_MUL && o_done |-> {o_ext, o_acc} == prod_w)
        else $error("product wrong");
    mul_flags_a: assert property (op_r == `AASU_OP_MUL && o_done
        |-> {o_carry, o_ovf} == {o_ext == {W{1'b0}}, o_ext[W-1]}) else $error("product flags wrong");
    div_fault_a: assert property (op_r == `AASU_OP_DIV && o_done && rd_r == {W{1'b0}}
        |-> o_acc == acc0_r && o_ext == ext0_r && o_carry && o_ovf) else $error("divide fault handling wrong");
    mul_time_a: assert property (op_r == `AASU_OP_MUL && rd_ack |-> ##[320:334] o_done)
        else $error("multiply latency wrong");
    div_time_a: assert property (op_r == `AASU_OP_DIV && rd_ack |-> ##[360:374] o_done)
        else $error("divide latency wrong");
    cover property (op_r == `AASU_OP_MUL && o_done);
    cover property (op_r == `AASU_OP_DIV && o_done && o_carry && o_ovf);
    cover property (o_mem_req && !i_mem_ack ##1 i_mem_ack);
endmodule // aasu_core_sva
bind aasu_core aasu_core_sva #(.W(W)) chk_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_start(i_start),
    .i_op(i_op), .i_addr(i_addr), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_acc(o_acc),
    .o_ext(o_ext), .o_carry(o_carry), .o_ovf(o_ovf), .o_busy(o_busy), .o_done(o_done));

// file: tb/aasu_core_tb_top.sv
// Self-checking bench for the accumulator arithmetic and store unit
`timescale 1ns/1ps
`include "aasu_regs.vh"
module aasu_core_tb_top;
    reg         sys_clk = 1'b0;
    reg         nrst = 1'b0;
    reg         start = 1'b0;
    reg         acc_we = 1'b0;
    reg         ext_we = 1'b0;
    reg         slow = 1'b0;
    reg  [3:0]  op = 4'h0;
    reg  [15:0] addr = 16'h0000;
    reg  [15:0] acc_wd = 16'h0000;
    reg  [15:0] ext_wd = 16'h0000;
    wire        mem_req, mem_we, mem_ack, carry, ovf, busy, done;
    wire [15:0] mem_addr, mem_wdata, mem_rdata, acc, ext;
    integer     fails = 0;
    integer     checks_done = 0;
    aasu_core dut_u (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_start(start), .i_op(op), .i_addr(addr),
        .i_acc_we(acc_we), .i_acc_wdata(acc_wd), .i_ext_we(ext_we), .i_ext_wdata(ext_wd),
        .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_acc(acc), .o_ext(ext), .o_carry(carry),
        .o_ovf(ovf), .o_busy(busy), .o_done(done));
    aasu_mem_model mem_u (.i_sys_clk(sys_clk), .i_slow(slow), .i_mem_req(mem_req), .i_mem_we(mem_we),
        .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task cyc;
        begin
            @(posedge sys_clk);
            #2;
        end
    endtask
    task chk(input [8*8-1:0] name, input [15:0] exp, input [15:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("comparisons %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task set_regs(input [15:0] a, input [15:0] e);
        begin
            cyc;
            acc_we = 1'b1;
            ext_we = 1'b1;
            acc_wd = a;
            ext_wd = e;
            cyc;
            acc_we = 1'b0;
            ext_we = 1'b0;
        end
    endtask
    task run_op(input [3:0] o, input [15:0] a);
        integer n;
        begin
            op = o;
            addr = a;
            start = 1'b1;
            cyc;
            start = 1'b0;
            n = 0;
            while (done !== 1'b1 && n < 2000) begin
                cyc;
                n = n + 1;
            end
            if (done !== 1'b1) begin
                fails = fails + 1;
                $display("ERROR done expected 1 seen timeout");
                finish_test;
            end
        end
    endtask
    task t_merge;
        begin
            slow = 1'b1;
            mem_u.mem_r[1] = 16'h1234;
            set_regs(16'hA5C3, 16'h0FF0);
            run_op(`AASU_OP_MMSTORE, 16'h0002);
            chk("mem", 16'h15C4, mem_u.mem_r[1]);
            chk("acc", 16'hA5C3, acc);
            chk("ext", 16'h0FF0, ext);
            chk("flags", 16'h0000, {14'h0000, carry, ovf});
            slow = 1'b0;
        end
    endtask
    task t_pair;
        begin
            set_regs(16'h1357, 16'h8642);
            run_op(`AASU_OP_PSTORE, 16'h0008);
            chk("mem", 16'h8642, mem_u.mem_r[4]);
            chk("mem", 16'h1357, mem_u.mem_r[5]);
            chk("acc", 16'h1357, acc);
            mem_u.mem_r[6] = 16'h0000;
            mem_u.mem_r[7] = 16'h8001;
            slow = 1'b1;
            run_op(`AASU_OP_PLOAD, 16'h000C);
            chk("ext", 16'h0000, ext);
            chk("acc", 16'h8001, acc);
            chk("flags", 16'h0002, {14'h0000, carry, ovf});
            slow = 1'b0;
        end
    endtask
    task t_arith(input [3:0] o, input [15:0] a, input [15:0] b);
        reg [16:0] r;
        reg        v;
        begin
            mem_u.mem_r[3] = b;
            set_regs(a, 16'h0000);
            run_op(o, 16'h0006);
            r = (o == `AASU_OP_SUB) ? {1'b0, a} + {1'b0, ~b} + 17'h00001 : {1'b0, a} + {1'b0, b};
            v = ((o == `AASU_OP_SUB) ? (a[15] != b[15]) : (a[15] == b[15])) && (r[15] != a[15]);
            chk("acc", r[15:0], acc);
            chk("flags", {14'h0000, r[16], v}, {14'h0000, carry, ovf});
            if (o == `AASU_OP_ADDMEM) chk("mem", r[15:0], mem_u.mem_r[3]);
        end
    endtask
    task t_mul(input [15:0] a, input [15:0] b);
        reg signed [31:0] p;
        begin
            mem_u.mem_r[2] = b;
            set_regs(a, 16'h0000);
            run_op(`AASU_OP_MUL, 16'h0004);
            p = $signed(a) * $signed(b);
            chk("ext", p[31:16], ext);
            chk("acc", p[15:0], acc);
            chk("flags", {14'h0000, p[31:16] == 16'h0000, p[31]}, {14'h0000, carry, ovf});
        end
    endtask
    task t_div(input [15:0] e, input [15:0] a, input [15:0] b);
        reg signed [31:0] d, s, q, r;
        reg               f;
        begin
            mem_u.mem_r[5] = b;
            set_regs(a, e);
            run_op(`AASU_OP_DIV, 16'h000A);
            d = {e, a};
            s = {{16{b[15]}}, b};
            f = (b == 16'h0000);
            if (!f) begin
                q = d / s;
                r = d % s;
                f = (q > 32767) || (q < -32768);
            end
            if (f) begin
                chk("acc", a, acc);
                chk("ext", e, ext);
                chk("flags", 16'h0003, {14'h0000, carry, ovf});
            end else begin
                chk("acc", q[15:0], acc);
                chk("ext", r[15:0], ext);
                chk("flags", {14'h0000, q[15:0] == 16'h0000, q[15]}, {14'h0000, carry, ovf});
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        #2;
        nrst = 1'b1;
        t_merge;
        t_pair;
        t_arith(`AASU_OP_ADD, 16'h7FFF, 16'h0001);
        t_arith(`AASU_OP_ADD, 16'hFFFF, 16'h0001);
        t_arith(`AASU_OP_ADDMEM, 16'h8000, 16'h8000);
        t_arith(`AASU_OP_SUB, 16'h0003, 16'h0005);
        t_arith(`AASU_OP_SUB, 16'h8000, 16'h0001);
        t_mul(16'hFFFD, 16'h1234);
        t_mul(16'h0005, 16'h0003);
        t_div(16'hFFFF, 16'hFF9C, 16'h0007);
        t_div(16'hFFFF, 16'hFF9E, 16'h0007);
        t_div(16'h1234, 16'h5678, 16'h0000);
        t_div(16'h0001, 16'h0000, 16'h0001);
        finish_test;
    end
endmodule // aasu_core_tb_top

// file: tb/aasu_mem_model.sv
// Behavioural word memory answering the unit's request port
`timescale 1ns/1ps
module aasu_mem_model (
    input  wire        i_sys_clk,
    input  wire        i_slow,
    input  wire        i_mem_req,
    input  wire        i_mem_we,
    input  wire [15:0] i_mem_addr,
    input  wire [15:0] i_mem_wdata,
    output reg         o_mem_ack,
    output reg  [15:0] o_mem_rdata
);
    reg [15:0] mem_r [0:15];
    reg [1:0]  wait_r;
    initial begin
        o_mem_ack = 1'b0;
        o_mem_rdata = 16'h0000;
        wait_r = 2'h0;
    end
    always @(posedge i_sys_clk) begin
        o_mem_ack <= 1'b0;
        // Data outside an ack is scrambled so a late sample cannot look right
        o_mem_rdata <= ~o_mem_rdata;
        if (i_mem_req && !o_mem_ack) begin
            if (i_slow && wait_r != 2'h3) begin
                wait_r <= wait_r + 2'h1;
            end else begin
                wait_r <= 2'h0;
                o_mem_ack <= 1'b1;
                if (i_mem_we) mem_r[i_mem_addr[4:1]] <= i_mem_wdata;
                else o_mem_rdata <= mem_r[i_mem_addr[4:1]];
            end
        end
    end
endmodule // aasu_mem_model
